// ===== common/tpc_pkg.sv
// constants for the prescaled 16-bit timer/counter
// assumes a byte-wide register port with 8-bit addresses
package tpc_pkg;
  // register offsets
  localparam logic [7:0] TPC_IRQ_ENABLE_ADDR  = 8'he8;
  localparam logic [7:0] TPC_CONTROL_ADDR     = 8'hea;
  localparam logic [7:0] TPC_IRQ_FLAGS_ADDR   = 8'hc8;
  localparam logic [7:0] TPC_COUNT_LOW_ADDR   = 8'hec;
  localparam logic [7:0] TPC_COUNT_HIGH_ADDR  = 8'hed;
  // reset values
  localparam logic [7:0] TPC_IRQ_ENABLE_RST   = 8'h00;
  localparam logic [7:0] TPC_CONTROL_RST      = 8'h00;
  // timer_control fields
  localparam int TPC_FULL_SEL_BIT  = 7;
  localparam int TPC_BYTE_SEL_BIT  = 6;
  localparam int TPC_CLR_EN_BIT    = 5;
  localparam int TPC_BYTE_FLAG_BIT = 4;
  localparam int TPC_DIV_LSB       = 2;
  localparam int TPC_SRC_LSB       = 0;
  // timer_irq_enable / timer_irq_flags fields
  localparam int TPC_WRAP_EN_BIT   = 7;
  localparam int TPC_FULL_FLAG_BIT = 7;
  // source select codes
  localparam logic [1:0] TPC_SRC_STOP = 2'h0;
  localparam logic [1:0] TPC_SRC_CLK6 = 2'h1;
  localparam logic [1:0] TPC_SRC_TEST = 2'h2;
  localparam logic [1:0] TPC_SRC_PIN  = 2'h3;
  // machine cycle timing: six system clocks per machine cycle
  localparam int TPC_CLK_HZ           = 20000000;
  localparam int TPC_MCYCLE_DIV       = 6;
  localparam int TPC_MCYCLE_CLKS      = TPC_MCYCLE_DIV;
  localparam logic [2:0] TPC_PH_SAMPLE_A = 3'h1;
  localparam logic [2:0] TPC_PH_SAMPLE_B = 3'h4;
  localparam logic [2:0] TPC_PH_LAST     = 3'(TPC_MCYCLE_CLKS - 1);
endpackage

// ===== core/tpc_timer.sv
// 16-bit free-running timer/counter with 1/2/4/8 prescaler and wrap flags
// assumes count, clear and idle inputs synchronous to clk_sys
// Function
// - count is sixteen bits, a high byte and a low byte
// - timer is stopped or clocked via prescaler from clock/6 or count pin
// - each count pin rising edge advances prescaler, at most once per machine cycle
// - pin sampled twice per machine cycle; low then high sample is an edge
// - early edge counts next machine cycle, late edge one cycle after that
// - prescaler divides by 1,2,4,8; cleared on factor, source change or reset
// - both count bytes readable while running, no snapshot latch
// - count not loadable; zeroed by reset or enabled clear-pin rising edge
// - byte wrap and full wrap flags set one machine cycle after overflow
// - setting the full wrap flag also sets the byte wrap flag
// - wrap request needs global enable and matching select bit, one output
// - flags are only cleared by software, each individually
// - clear-pin reset also clears the prescaler
// - idle mode holds count and prescaler in reset and stops counting
// - irq enable register bits: wrap, bus ctrl, cmp1, cmp0, cap3..cap0
// - control register: full sel, byte sel, clear en, byte flag, div, source
// - divider code 00,01,10,11 divides by 1,2,4,8
// - source code 00 stop, 01 clock/6, 10 test reserved, 11 count pin
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module tpc_timer
  import tpc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // pins and power state
  input  wire logic       ext_count_pin,
  input  wire logic       ext_clear_pin,
  input  wire logic       idle_mode,
  // interrupt request
  output logic            wrap_irq_req
);

  function automatic logic [2:0] div_last(input logic [1:0] code);
    div_last = 3'((4'h1 << code) - 4'h1);
  endfunction

  logic       rst_meta_reg;
  logic       rst_sync_reg;
  wire        rst_n = rst_sync_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic [7:0]  irq_enable_reg;
  logic [7:0]  control_reg;
  logic        full_flag_reg;
  logic [15:0] count_reg;
  logic [2:0]  phase_reg;
  logic [2:0]  presc_reg;
  logic        pin_samp_reg;
  logic        early_reg;
  logic        late_reg;
  logic        pend_reg;
  logic        stage_reg;
  logic        clr_pin_reg;
  logic        byte_ovf_reg;
  logic        full_ovf_reg;
  logic [3:0]  ctrl_prev_reg;
  logic [7:0]  rd_data_reg;
  logic        irq_reg;

  // register decode
  wire wr_ctrl  = wr_en && (addr == TPC_CONTROL_ADDR);
  wire wr_ien   = wr_en && (addr == TPC_IRQ_ENABLE_ADDR);
  wire wr_flags = wr_en && (addr == TPC_IRQ_FLAGS_ADDR);

  wire [1:0] src_sel = control_reg[TPC_SRC_LSB +: 2];
  wire [1:0] div_sel = control_reg[TPC_DIV_LSB +: 2];
  wire       mc_end  = (phase_reg == TPC_PH_LAST);
  wire       samp_a  = (phase_reg == TPC_PH_SAMPLE_A);
  wire       samp_b  = (phase_reg == TPC_PH_SAMPLE_B);

  // pin sampled at the two sample phases only
  wire       samp_now  = samp_a || samp_b;
  wire       pin_edge  = samp_now && !pin_samp_reg && ext_count_pin;

  // ext clear: rising edge while enabled
  wire       clr_edge  = ext_clear_pin && !clr_pin_reg
                         && control_reg[TPC_CLR_EN_BIT];
  // prescaler is cleared on a change of its factor or source
  wire       cfg_change = (ctrl_prev_reg != control_reg[3:0]);
  wire       presc_clr  = clr_edge || idle_mode || cfg_change;

  // source tick into the prescaler, at most one per machine cycle
  wire       src_tick = mc_end && !idle_mode &&
                        (((src_sel == TPC_SRC_CLK6)) ||
                         ((src_sel == TPC_SRC_PIN) && stage_reg));
  wire       presc_out = src_tick && !presc_clr &&
                         (presc_reg == div_last(div_sel));

  wire [15:0] count_inc = count_reg + 16'h0001;
  wire        low_wrap  = presc_out && (count_reg[7:0] == 8'hff);
  wire        full_wrap = presc_out && (count_reg == 16'hffff);

  // flag set one machine cycle after the overflow
  wire set_full = mc_end && full_ovf_reg;
  wire set_byte = mc_end && (byte_ovf_reg || full_ovf_reg);

  // software clear only; a set in the same cycle wins
  wire byte_flag_next = set_byte ||
       (wr_ctrl ? wr_data[TPC_BYTE_FLAG_BIT] : control_reg[TPC_BYTE_FLAG_BIT]);
  wire full_flag_next = set_full ||
       (wr_flags ? wr_data[TPC_FULL_FLAG_BIT] : full_flag_reg);

  wire irq_next = irq_enable_reg[TPC_WRAP_EN_BIT] &&
       ((control_reg[TPC_BYTE_SEL_BIT] && control_reg[TPC_BYTE_FLAG_BIT]) ||
        (control_reg[TPC_FULL_SEL_BIT] && full_flag_reg));

  // live read of both bytes, carry may land between reads
  wire [7:0] rd_next =
       (addr == TPC_IRQ_ENABLE_ADDR) ? irq_enable_reg :
       (addr == TPC_CONTROL_ADDR)    ? control_reg :
       (addr == TPC_IRQ_FLAGS_ADDR)  ? {full_flag_reg, 7'h00} :
       (addr == TPC_COUNT_LOW_ADDR)  ? count_reg[7:0] :
       (addr == TPC_COUNT_HIGH_ADDR) ? count_reg[15:8] : 8'h00;

  // machine cycle phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= mc_end ? 3'h0 : phase_reg + 3'h1;
    end
  end

  // edge pipeline: early edge fires end of next cycle, late one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_samp_reg <= 1'b0;
      early_reg    <= 1'b0;
      late_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      stage_reg    <= 1'b0;
    end else begin
      if (samp_now) begin
        pin_samp_reg <= ext_count_pin;
      end
      if (mc_end) begin
        stage_reg <= early_reg || pend_reg;
        pend_reg  <= late_reg;
        early_reg <= 1'b0;
        late_reg  <= 1'b0;
      end else begin
        if (pin_edge && samp_a) begin
          early_reg <= 1'b1;
        end
        if (pin_edge && samp_b) begin
          late_reg <= 1'b1;
        end
      end
    end
  end

  // prescaler and counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= 3'h0;
      count_reg <= 16'h0000;
    end else begin
      if (presc_clr || presc_out) begin
        presc_reg <= 3'h0;
      end else if (src_tick) begin
        presc_reg <= presc_reg + 3'h1;
      end
      // no write path: only reset, clear pin and idle zero it
      if (clr_edge || idle_mode) begin
        count_reg <= 16'h0000;
      end else if (presc_out) begin
        count_reg <= count_inc;
      end
    end
  end

  // overflow pending until end of following machine cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      byte_ovf_reg <= 1'b0;
      full_ovf_reg <= 1'b0;
    end else begin
      if (low_wrap) begin
        byte_ovf_reg <= 1'b1;
      end else if (mc_end) begin
        byte_ovf_reg <= 1'b0;
      end
      if (full_wrap) begin
        full_ovf_reg <= 1'b1;
      end else if (mc_end) begin
        full_ovf_reg <= 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= TPC_IRQ_ENABLE_RST;
      control_reg    <= TPC_CONTROL_RST;
      full_flag_reg  <= 1'b0;
      ctrl_prev_reg  <= TPC_CONTROL_RST[3:0];
      clr_pin_reg    <= 1'b0;
    end else begin
      if (wr_ien) begin
        irq_enable_reg <= wr_data;
      end
      if (wr_ctrl) begin
        control_reg[7:5] <= wr_data[7:5];
        control_reg[3:0] <= wr_data[3:0];
      end
      control_reg[TPC_BYTE_FLAG_BIT] <= byte_flag_next;
      full_flag_reg <= full_flag_next;
      ctrl_prev_reg <= control_reg[3:0];
      clr_pin_reg   <= ext_clear_pin;
    end
  end

  // outputs from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
      irq_reg     <= 1'b0;
    end else begin
      rd_data_reg <= rd_en ? rd_next : 8'h00;
      irq_reg     <= irq_next;
    end
  end

  assign rd_data      = rd_data_reg;
  assign wrap_irq_req = irq_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_full_ovf;
    full_wrap;
  endsequence
  // wrap at a machine cycle end, flag flop set at the next end, seen one edge later
  sequence s_flags_set;
    ##7 (full_flag_reg && control_reg[TPC_BYTE_FLAG_BIT]);
  endsequence
  sequence s_byte_set;
    ##7 control_reg[TPC_BYTE_FLAG_BIT];
  endsequence

  count_step_a: assert property (presc_out && !clr_edge && !idle_mode |=>
    count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step on prescaler tick");
  count_hold_a: assert property (!presc_out && !clr_edge && !idle_mode |=>
    count_reg == $past(count_reg))
    else $error("count changed without a tick");
  clear_pin_a: assert property (clr_edge |=> count_reg == 16'h0000 && presc_reg == 3'h0)
    else $error("clear pin did not zero count and prescaler");
  idle_hold_a: assert property (idle_mode |=> count_reg == 16'h0000 && presc_reg == 3'h0)
    else $error("idle did not hold timer in reset");
  full_flags_a: assert property (s_full_ovf |-> s_flags_set)
    else $error("full wrap did not set both flags");
  flag_sticky_a: assert property (full_flag_reg && !wr_flags |=> full_flag_reg)
    else $error("full wrap flag cleared without software");
  // one edge of slack after a config change, the clear lands one clock late
  div_bound_a: assert property (!cfg_change |-> presc_reg <= div_last(div_sel))
    else $error("prescaler ran past its division factor");
  byte_flag_a: assert property (low_wrap |-> s_byte_set)
    else $error("low byte wrap did not set the byte flag");
  early_edge_a: assert property (pin_edge && samp_a |->
    ##10 (src_tick || src_sel != TPC_SRC_PIN || idle_mode))
    else $error("early pin edge not counted in next machine cycle");
  late_edge_a: assert property (pin_edge && samp_b |->
    ##13 (src_tick || src_sel != TPC_SRC_PIN || idle_mode))
    else $error("late pin edge not counted one machine cycle later");
  one_tick_a: assert property (src_tick |=> !src_tick [*5])
    else $error("more than one source tick per machine cycle");
  irq_gate_a: assert property (wrap_irq_req |->
    $past(irq_enable_reg[TPC_WRAP_EN_BIT]))
    else $error("wrap request without global enable");
  stop_mode_a: assert property ((src_sel == TPC_SRC_STOP) |-> !src_tick)
    else $error("stopped timer ticked");

endmodule // tpc_timer

// ===== test/tpc_pin_model.sv
// drives the external count and clear pins of the timer
// assumes the bench calls its tasks in the clk_sys domain
`timescale 1ns/1ns
module tpc_pin_model (
  // clock
  input  wire logic clk_sys,
  // pins
  output logic      ext_count_pin,
  output logic      ext_clear_pin
);
  initial begin
    ext_count_pin = 1'b0;
    ext_clear_pin = 1'b0;
  end
  // hold of 3 is half a machine cycle, the fastest legal rate
  task automatic pulse_count(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge clk_sys);
      ext_count_pin <= 1'b1;
      repeat (hold) @(posedge clk_sys);
      ext_count_pin <= 1'b0;
    end
  endtask
  // one rising edge, then back low
  task automatic pulse_clear();
    @(posedge clk_sys);
    ext_clear_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ext_clear_pin <= 1'b0;
  endtask
endmodule // tpc_pin_model

// ===== test/tb_timer2_prescaled_counter.sv
// self-checking bench for the prescaled timer/counter
// assumes tpc_timer and tpc_pin_model; full 16-bit wrap too long to reach
`timescale 1ns/1ns
module tb_timer2_prescaled_counter;
  import tpc_pkg::*;
  logic       clk_sys;
  logic       arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rd_data;
  logic       ext_count_pin;
  logic       ext_clear_pin;
  logic       idle_mode = 1'b0;
  logic       wrap_irq_req;
  int         failures = 0;
  int         num_checks = 0;
  int         cycles = 0;
  logic [7:0] a_v;
  logic [7:0] b_v;

  tpc_timer i_tpc_timer (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ext_count_pin(ext_count_pin), .ext_clear_pin(ext_clear_pin),
    .idle_mode(idle_mode), .wrap_irq_req(wrap_irq_req));
  tpc_pin_model i_tpc_pin_model (.clk_sys(clk_sys), .ext_count_pin(ext_count_pin),
    .ext_clear_pin(ext_clear_pin));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask
  // window is four prescaler periods, so exactly four ticks when running
  task automatic rate(input logic [1:0] src, input logic [1:0] dv, input logic [7:0] exp);
    logic [7:0] a;
    logic [7:0] b;
    wr(TPC_CONTROL_ADDR, {4'h0, dv, src});
    repeat (12) @(posedge clk_sys);
    rd(TPC_COUNT_LOW_ADDR, a);
    // the two reads sample exactly four prescaler periods apart
    repeat (24 * (1 << dv) - 2) @(posedge clk_sys);
    rd(TPC_COUNT_LOW_ADDR, b);
    chk(8'(b - a), exp, "count rate");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk(TPC_IRQ_ENABLE_ADDR, TPC_IRQ_ENABLE_RST, "enable reset");
    rd_chk(TPC_CONTROL_ADDR, TPC_CONTROL_RST, "control reset");
    rd_chk(TPC_COUNT_HIGH_ADDR, 8'h00, "count high reset");
    rd_chk(8'h00, 8'h00, "unmapped read");
    wr(TPC_IRQ_ENABLE_ADDR, 8'ha5);
    rd_chk(TPC_IRQ_ENABLE_ADDR, 8'ha5, "enable rw");
    wr(TPC_CONTROL_ADDR, 8'he0);
    rd_chk(TPC_CONTROL_ADDR, 8'he0, "control rw");
    $display("test registers done");
    for (int s = 0; s < 4; s++) rate(2'(s), 2'h0, (s == 1) ? 8'h04 : 8'h00);
    for (int d = 0; d < 4; d++) rate(TPC_SRC_CLK6, 2'(d), 8'h04);
    $display("test rates done");
    wr(TPC_CONTROL_ADDR, 8'h03);
    rd(TPC_COUNT_LOW_ADDR, a_v);
    i_tpc_pin_model.pulse_count(5, 3);
    i_tpc_pin_model.pulse_count(3, 7);
    repeat (18) @(posedge clk_sys);
    rd(TPC_COUNT_LOW_ADDR, b_v);
    chk(8'(b_v - a_v), 8'h08, "pin edges");
    i_tpc_pin_model.pulse_clear();
    repeat (6) @(posedge clk_sys);
    rd_chk(TPC_COUNT_LOW_ADDR, b_v, "clear ignored");
    wr(TPC_CONTROL_ADDR, 8'h27);
    i_tpc_pin_model.pulse_clear();
    i_tpc_pin_model.pulse_count(1, 3);
    repeat (18) @(posedge clk_sys);
    i_tpc_pin_model.pulse_clear();
    i_tpc_pin_model.pulse_count(1, 3);
    repeat (18) @(posedge clk_sys);
    rd_chk(TPC_COUNT_LOW_ADDR, 8'h00, "clear with prescaler");
    rd_chk(TPC_COUNT_HIGH_ADDR, 8'h00, "clear high");
    $display("test pins done");
    wr(TPC_IRQ_ENABLE_ADDR, 8'h80);
    wr(TPC_CONTROL_ADDR, 8'h01);
    repeat (30) @(posedge clk_sys);
    idle_mode <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rd_chk(TPC_COUNT_LOW_ADDR, 8'h00, "idle low");
    rd_chk(TPC_COUNT_HIGH_ADDR, 8'h00, "idle high");
    idle_mode <= 1'b0;
    $display("test idle done");
    repeat (1566) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h00, "irq unselected");
    rd_chk(TPC_CONTROL_ADDR, 8'h11, "byte flag");
    rd_chk(TPC_IRQ_FLAGS_ADDR, 8'h00, "no full flag");
    rd_chk(TPC_COUNT_HIGH_ADDR, 8'h01, "carry into high");
    wr(TPC_CONTROL_ADDR, 8'h51);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h01, "irq selected");
    wr(TPC_IRQ_ENABLE_ADDR, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h00, "irq global off");
    wr(TPC_IRQ_ENABLE_ADDR, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h01, "flag kept");
    wr(TPC_CONTROL_ADDR, 8'h41);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h00, "flag cleared");
    rd_chk(TPC_CONTROL_ADDR, 8'h41, "flag reads clear");
    wr(TPC_IRQ_FLAGS_ADDR, 8'h80);
    rd_chk(TPC_IRQ_FLAGS_ADDR, 8'h80, "full flag set");
    wr(TPC_CONTROL_ADDR, 8'h81);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h01, "irq full selected");
    wr(TPC_IRQ_FLAGS_ADDR, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(wrap_irq_req), 8'h00, "full flag cleared");
    rd_chk(TPC_IRQ_FLAGS_ADDR, 8'h00, "full flag reads clear");
    $display("test wrap done");
    summarize();
  end
endmodule // tb_timer2_prescaled_counter
